// *** logic/lcsr_pkg.sv ***
// Package for the regulator control and status register bank.
// Assumes a 125 MHz device clock and a byte-wide register port.
package lcsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LCSR_ADDR_FIRST_LINEAR_REGULATOR_STATUS = 8'h60;
  localparam logic [7:0] LCSR_ADDR_FIRST_LINEAR_REGULATOR_CTRL   = 8'h62;
  localparam logic [7:0] LCSR_ADDR_FIRST_LINEAR_REGULATOR_SEQ    = 8'h63;
  localparam logic [7:0] LCSR_ADDR_FIRST_LINEAR_REGULATOR_SPARE  = 8'h64;
  localparam logic [7:0] LCSR_ADDR_SECOND_LINEAR_REGULATOR_STATUS = 8'h65;
  localparam logic [7:0] LCSR_ADDR_SECOND_LINEAR_REGULATOR_VCODE  = 8'h66;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LCSR_RST_FIRST_LINEAR_REGULATOR_CTRL  = 8'h98;
  localparam logic [7:0] LCSR_RST_FIRST_LINEAR_REGULATOR_SEQ   = 8'h82;
  localparam logic [7:0] LCSR_RST_FIRST_LINEAR_REGULATOR_SPARE = 8'h00;
  localparam logic [7:0] LCSR_RST_MASKS      = 8'h00;
  localparam logic [7:0] LCSR_RST_VCODE      = 8'h50;

  // ----------------------------------------------------------------
  // Field positions in the status and mask registers
  // ----------------------------------------------------------------
  localparam int LCSR_BIT_PG       = 7;
  localparam int LCSR_BIT_OV       = 6;
  localparam int LCSR_BIT_ILIM     = 5;
  localparam int LCSR_BIT_UV_MSK   = 3;
  localparam int LCSR_BIT_OV_MSK   = 2;
  localparam int LCSR_BIT_ILIM_MSK = 1;
  localparam int LCSR_BIT_RSVD0    = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LCSR_CLK_PERIOD_NS = 8;
  localparam int LCSR_STEP_NS       = 250000;
  localparam int LCSR_STEP_CYCLES   = LCSR_STEP_NS / LCSR_CLK_PERIOD_NS;
  localparam int LCSR_RETRY_MS      = 10;
  localparam int LCSR_RETRY_STEPS   = LCSR_RETRY_MS * 1000000 / LCSR_STEP_NS;
  localparam logic [5:0] LCSR_ON_DLY_00 = 6'h00;
  localparam logic [5:0] LCSR_ON_DLY_01 = 6'h01;
  localparam logic [5:0] LCSR_ON_DLY_10 = 6'h02;
  localparam logic [5:0] LCSR_ON_DLY_11 = 6'h04;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic       sleep_off;
    logic       deep_sleep_off;
    logic [1:0] current_limit_select;
    logic       reset_influence;
    logic       limit_shutdown;
    logic       rsvd;
  } lcsr_ctrl_t;

  typedef struct packed {
    logic       hold_on;
    logic [1:0] turn_on_delay;
    logic [4:0] turn_off_delay;
  } lcsr_seq_t;

  typedef struct packed {
    logic pg;
    logic ov;
    logic ilim;
    logic uv;
  } lcsr_mon_t;

  typedef enum logic [2:0] {
    LCSR_OFF      = 3'b000,
    LCSR_ON_WAIT  = 3'b001,
    LCSR_ON       = 3'b010,
    LCSR_OFF_WAIT = 3'b011,
    LCSR_RETRY    = 3'b100
  } lcsr_state_t;

endpackage

// *** logic/lcsr_regs.sv ***
// Control and status registers for the two linear regulators.
// Assumes an upstream I2C byte engine issues one-cycle read and write
// strobes; comparator and mode inputs are asynchronous.
`timescale 1ns/1ps

// Overview of operation
// - Control bit 7 enables regulator, resets one
// - Sleep-off bit turns regulator off in sleep
// - Deep-sleep-off bit turns regulator off in deep-sleep
// - Bits 4:3 select current limit, reset 11
// - Reset-influence bit lets regulator gate reset
// - Limit-shutdown bit stops regulator, restarts 10ms later
// - Hold-on bit keeps regulator on after predecessor
// - Turn-on delay field waits 0 to 1ms
// - Turn-off delay is field times 0.25ms
// - Status bit 7 shows live power-good
// - Over-voltage flag sticky until gone and read
// - Unmasked under-voltage drives interrupt and fault state
// - Unmasked over-voltage holds interrupt, enters fault state
// - Current-limit flag sticky; unmasked holds interrupt
// - Voltage code register resets to 0x50
// - First regulator has same status and masks
module lcsr_regs
  import lcsr_pkg::*;
#(
  parameter int STEP_CYCLES  = LCSR_STEP_CYCLES,
  parameter int RETRY_STEPS  = LCSR_RETRY_STEPS
)(
  input  wire logic       i_clk,            // Device clock, 125 MHz
  input  wire logic       i_rst,            // Synchronous reset, high
  input  wire logic [7:0] i_reg_addr,       // Register address
  input  wire logic [7:0] i_reg_wdata,      // Write data
  input  wire logic       i_reg_wr,         // Write strobe, one cycle
  input  wire logic       i_reg_rd,         // Read strobe, one cycle
  output logic      [7:0] o_reg_rdata,      // Read data, next cycle
  input  wire logic [3:0] i_first_linear_regulator_mon,       // Regulator 1 pg/ov/ilim/uv
  input  wire logic [3:0] i_second_linear_regulator_mon,       // Regulator 2 pg/ov/ilim/uv
  input  wire logic       i_sleep_mode,     // Sleep mode request
  input  wire logic       i_deep_sleep_mode,// Deep-sleep mode request
  input  wire logic       i_start_trigger,  // Regulator 1 start trigger
  input  wire logic       i_prev_rail_down, // Preceding rail shut down
  output logic            o_first_linear_regulator_enable,    // Regulator 1 turn on
  output logic      [1:0] o_first_linear_regulator_ilim_sel,  // Regulator 1 limit code
  output logic      [7:0] o_second_linear_regulator_vcode,     // Regulator 2 voltage code
  output logic            o_reset_output_n, // Reset hold, low active
  output logic            o_interrupt_output_n, // Fault interrupt, low
  output logic            o_fault_state     // Device in fault state
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NIN = 12;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;
  logic [NIN-1:0] sync3_r;
  logic [NIN-1:0] clean_r;

  assign raw_in = {i_prev_rail_down, i_start_trigger, i_deep_sleep_mode,
                   i_sleep_mode, i_second_linear_regulator_mon, i_first_linear_regulator_mon};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_sync
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          clean_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi])
            clean_r[gi] <= sync3_r[gi];
        end
      end
    end
  endgenerate

  lcsr_mon_t mon1;
  lcsr_mon_t mon2;
  logic      sleep_in;
  logic      deep_in;
  logic      start_in;
  logic      prev_down;

  assign mon1      = clean_r[3:0];
  assign mon2      = clean_r[7:4];
  assign sleep_in  = clean_r[8];
  assign deep_in   = clean_r[9];
  assign start_in  = clean_r[10];
  assign prev_down = clean_r[11];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  lcsr_ctrl_t ctrl_r;
  lcsr_seq_t  seq_r;
  logic [7:0] spare_r;
  logic [3:0] mask1_r;
  logic [3:0] mask2_r;
  logic [7:0] vcode_r;
  logic       ov1_r;
  logic       il1_r;
  logic       ov2_r;
  logic       il2_r;

  wire wr_ctrl  = i_reg_wr && (i_reg_addr == LCSR_ADDR_FIRST_LINEAR_REGULATOR_CTRL);
  wire wr_seq   = i_reg_wr && (i_reg_addr == LCSR_ADDR_FIRST_LINEAR_REGULATOR_SEQ);
  wire wr_spare = i_reg_wr && (i_reg_addr == LCSR_ADDR_FIRST_LINEAR_REGULATOR_SPARE);
  wire wr_st1   = i_reg_wr && (i_reg_addr == LCSR_ADDR_FIRST_LINEAR_REGULATOR_STATUS);
  wire wr_st2   = i_reg_wr && (i_reg_addr == LCSR_ADDR_SECOND_LINEAR_REGULATOR_STATUS);
  wire wr_vcode = i_reg_wr && (i_reg_addr == LCSR_ADDR_SECOND_LINEAR_REGULATOR_VCODE);
  wire rd_st1   = i_reg_rd && (i_reg_addr == LCSR_ADDR_FIRST_LINEAR_REGULATOR_STATUS);
  wire rd_st2   = i_reg_rd && (i_reg_addr == LCSR_ADDR_SECOND_LINEAR_REGULATOR_STATUS);

  wire [7:0] st1_val = {mon1.pg, ov1_r, il1_r, 1'b0, mask1_r};
  wire [7:0] st2_val = {mon2.pg, ov2_r, il2_r, 1'b0, mask2_r};

  logic [7:0] rd_mux;
  always_comb
  begin
    case (i_reg_addr)
      LCSR_ADDR_FIRST_LINEAR_REGULATOR_STATUS: rd_mux = st1_val;
      LCSR_ADDR_FIRST_LINEAR_REGULATOR_CTRL:   rd_mux = ctrl_r;
      LCSR_ADDR_FIRST_LINEAR_REGULATOR_SEQ:    rd_mux = seq_r;
      LCSR_ADDR_FIRST_LINEAR_REGULATOR_SPARE:  rd_mux = spare_r;
      LCSR_ADDR_SECOND_LINEAR_REGULATOR_STATUS: rd_mux = st2_val;
      LCSR_ADDR_SECOND_LINEAR_REGULATOR_VCODE:  rd_mux = vcode_r;
      default:               rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Enable resets set; limit code resets 11
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ctrl_r      <= LCSR_RST_FIRST_LINEAR_REGULATOR_CTRL;
      seq_r       <= LCSR_RST_FIRST_LINEAR_REGULATOR_SEQ;
      spare_r     <= LCSR_RST_FIRST_LINEAR_REGULATOR_SPARE;
      mask1_r     <= LCSR_RST_MASKS[3:0];
      mask2_r     <= LCSR_RST_MASKS[3:0];
      vcode_r     <= LCSR_RST_VCODE;
      o_reg_rdata <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= i_reg_wdata;
      if (wr_seq)
        seq_r <= i_reg_wdata;
      if (wr_spare)
        spare_r <= i_reg_wdata;
      // Same mask layout on both regulators
      if (wr_st1)
        mask1_r <= i_reg_wdata[LCSR_BIT_UV_MSK:LCSR_BIT_RSVD0];
      if (wr_st2)
        mask2_r <= i_reg_wdata[LCSR_BIT_UV_MSK:LCSR_BIT_RSVD0];
      if (wr_vcode)
        vcode_r <= i_reg_wdata;
      if (i_reg_rd)
        o_reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Sticky fault flags
  // ----------------------------------------------------------------
  // Set on condition; read clears only if gone
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ov1_r <= 1'b0;
      il1_r <= 1'b0;
      ov2_r <= 1'b0;
      il2_r <= 1'b0;
    end
    else
    begin
      ov1_r <= mon1.ov   | (ov1_r & ~rd_st1);
      il1_r <= mon1.ilim | (il1_r & ~rd_st1);
      ov2_r <= mon2.ov   | (ov2_r & ~rd_st2);
      il2_r <= mon2.ilim | (il2_r & ~rd_st2);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt, fault state and reset influence
  // ----------------------------------------------------------------
  // Unmasked under-voltage is live
  wire uv_src = (mon1.uv & ~mask1_r[LCSR_BIT_UV_MSK]) |
                (mon2.uv & ~mask2_r[LCSR_BIT_UV_MSK]);
  // Unmasked over-voltage held by sticky flag
  wire ov_src = (ov1_r & ~mask1_r[LCSR_BIT_OV_MSK]) |
                (ov2_r & ~mask2_r[LCSR_BIT_OV_MSK]);
  // Unmasked current limit held by sticky flag
  wire il_src = (il1_r & ~mask1_r[LCSR_BIT_ILIM_MSK]) |
                (il2_r & ~mask2_r[LCSR_BIT_ILIM_MSK]);
  // Any unmasked source pulls interrupt low
  wire irq_any = uv_src | ov_src | il_src;
  // Regulator gates reset only when influence bit set
  wire rst_hold = ctrl_r.reset_influence & ~mon1.pg;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_interrupt_output_n <= 1'b1;
      o_fault_state        <= 1'b0;
      o_reset_output_n     <= 1'b1;
    end
    else
    begin
      o_interrupt_output_n <= ~irq_any;
      o_fault_state        <= uv_src | ov_src;
      o_reset_output_n     <= ~rst_hold;
    end
  end

  // ----------------------------------------------------------------
  // Regulator 1 sequencing
  // ----------------------------------------------------------------
  localparam int PW = $clog2(STEP_CYCLES + 1);
  localparam logic [PW-1:0] STEP_LAST = PW'(STEP_CYCLES - 1);
  localparam logic [5:0]    RETRY_CNT = 6'(RETRY_STEPS);

  lcsr_state_t state_r;
  lcsr_state_t state_nxt;
  logic [PW-1:0] pre_r;
  logic [5:0]    dly_r;
  logic [5:0]    dly_nxt;
  logic          load;

  // Predecessor loss stops unless hold-on set
  wire run_ok = ctrl_r.enable & start_in & ~(prev_down & ~seq_r.hold_on);
  wire sleep_off = (sleep_in & ctrl_r.sleep_off) |
                   (deep_in & ctrl_r.deep_sleep_off);
  wire step      = (pre_r == STEP_LAST);
  wire dly_done  = (dly_r == 6'h00);

  logic [5:0] on_dly;
  always_comb
  begin
    case (seq_r.turn_on_delay)
      2'b00:   on_dly = LCSR_ON_DLY_00;
      2'b01:   on_dly = LCSR_ON_DLY_01;
      2'b10:   on_dly = LCSR_ON_DLY_10;
      default: on_dly = LCSR_ON_DLY_11;
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    dly_nxt   = dly_r;
    load      = 1'b0;
    case (state_r)
      LCSR_OFF:
      begin
        if (run_ok && !sleep_off)
        begin
          state_nxt = LCSR_ON_WAIT;
          dly_nxt   = on_dly;
          load      = 1'b1;
        end
      end
      LCSR_ON_WAIT:
      begin
        if (!run_ok)
          state_nxt = LCSR_OFF;
        else if (dly_done)
          state_nxt = LCSR_ON;
      end
      LCSR_ON:
      begin
        if (!run_ok)
          state_nxt = LCSR_OFF;
        else if (sleep_off)
        begin
          // Turn-off delay is field times one step
          state_nxt = LCSR_OFF_WAIT;
          dly_nxt   = {1'b0, seq_r.turn_off_delay};
          load      = 1'b1;
        end
        else if (mon1.ilim && ctrl_r.limit_shutdown)
        begin
          // Shut down, restart after retry time
          state_nxt = LCSR_RETRY;
          dly_nxt   = RETRY_CNT;
          load      = 1'b1;
        end
      end
      LCSR_OFF_WAIT:
      begin
        if (!run_ok || dly_done)
          state_nxt = LCSR_OFF;
        else if (!sleep_off)
          state_nxt = LCSR_ON;
      end
      LCSR_RETRY:
      begin
        if (!run_ok)
          state_nxt = LCSR_OFF;
        else if (dly_done)
          state_nxt = LCSR_ON;
      end
      default:
        state_nxt = LCSR_OFF;
    endcase
    if (!load && step && !dly_done)
      dly_nxt = dly_r - 6'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_r <= LCSR_OFF;
      dly_r   <= 6'h00;
      pre_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      dly_r   <= dly_nxt;
      pre_r   <= (load || step) ? '0 : pre_r + PW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the analog side
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_first_linear_regulator_enable   <= 1'b0;
      o_first_linear_regulator_ilim_sel <= LCSR_RST_FIRST_LINEAR_REGULATOR_CTRL[4:3];
      o_second_linear_regulator_vcode    <= LCSR_RST_VCODE;
    end
    else
    begin
      o_first_linear_regulator_enable   <= (state_nxt == LCSR_ON) ||
                         (state_nxt == LCSR_OFF_WAIT);
      o_first_linear_regulator_ilim_sel <= ctrl_r.current_limit_select;
      o_second_linear_regulator_vcode    <= vcode_r;
    end
  end

endmodule

// *** dv/lcsr_monitor.sv ***
// Port checker for the regulator register bank.
// Assumes a single clock and a synchronous high reset.
`timescale 1ns/1ps
module lcsr_monitor
  import lcsr_pkg::*;
(
  input wire logic       i_clk,                // Clock
  input wire logic       i_rst,                // Reset
  input wire logic [7:0] i_reg_addr,           // Address
  input wire logic [7:0] i_reg_wdata,          // Write data
  input wire logic       i_reg_wr,             // Write strobe
  input wire logic       i_reg_rd,             // Read strobe
  input wire logic [7:0] o_reg_rdata,          // Read data
  input wire logic [3:0] i_first_linear_regulator_mon,           // Monitor 1
  input wire logic [3:0] i_second_linear_regulator_mon,           // Monitor 2
  input wire logic       i_start_trigger,      // Start
  input wire logic       o_first_linear_regulator_enable,        // Enable
  input wire logic [1:0] o_first_linear_regulator_ilim_sel,      // Limit code
  input wire logic [7:0] o_second_linear_regulator_vcode,         // Voltage code
  input wire logic       o_reset_output_n,     // Reset out
  input wire logic       o_interrupt_output_n, // Interrupt
  input wire logic       o_fault_state         // Fault
);
  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire unmap_w = i_reg_addr != 8'h60 &&
                 (i_reg_addr < 8'h62 || i_reg_addr > 8'h66);
  sequence s_wr_ctrl;
    i_reg_wr && i_reg_addr == 8'h62;
  endsequence
  a_reset_vals: assert property ($fell(i_rst) |->
    o_second_linear_regulator_vcode == 8'h50 && o_first_linear_regulator_ilim_sel == 2'h3 &&
    o_interrupt_output_n && !o_fault_state) else $error("reset value");
  a_vcode_write: assert property (i_reg_wr &&
    i_reg_addr == 8'h66 |-> ##2 o_second_linear_regulator_vcode == $past(i_reg_wdata, 2))
    else $error("voltage code not written");
  a_ilim_write: assert property (s_wr_ctrl |-> ##2
    o_first_linear_regulator_ilim_sel == $past(i_reg_wdata[4:3], 2)) else $error("limit code");
  a_enable_off: assert property (s_wr_ctrl ##0
    !i_reg_wdata[7] |-> ##[1:3] !o_first_linear_regulator_enable) else $error("not off");
  a_unmap_read: assert property (i_reg_rd && unmap_w |=>
    o_reg_rdata == 8'h00) else $error("unmapped read");
  a_vcode_read: assert property (i_reg_rd &&
    i_reg_addr == 8'h66 |=> o_reg_rdata == $past(o_second_linear_regulator_vcode))
    else $error("voltage code read");
  a_start_low: assert property ((!i_start_trigger)[*8] |->
    !o_first_linear_regulator_enable) else $error("on without trigger");
  a_pg_reset: assert property ((i_first_linear_regulator_mon[3])[*8] |->
    o_reset_output_n) else $error("reset held with power good");
  a_rdata_hold: assert property (!i_reg_rd |=>
    $stable(o_reg_rdata)) else $error("read data moved");
  a_fault_irq: assert property (o_fault_state |->
    ##[0:1] !o_interrupt_output_n) else $error("fault without irq");
endmodule

bind lcsr_regs lcsr_monitor mon_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_first_linear_regulator_mon(i_first_linear_regulator_mon),
  .i_second_linear_regulator_mon(i_second_linear_regulator_mon), .i_start_trigger(i_start_trigger),
  .o_first_linear_regulator_enable(o_first_linear_regulator_enable), .o_first_linear_regulator_ilim_sel(o_first_linear_regulator_ilim_sel),
  .o_second_linear_regulator_vcode(o_second_linear_regulator_vcode), .o_reset_output_n(o_reset_output_n),
  .o_interrupt_output_n(o_interrupt_output_n),
  .o_fault_state(o_fault_state));

// *** dv/lcsr_host.sv ***
// Host model issuing register strobes.
// Assumes one-cycle strobes taken on the rising edge.
`timescale 1ns/1ps
module lcsr_host (
  input  wire logic       i_clk,   // Clock
  input  wire logic [7:0] i_rdata, // Read data
  output logic      [7:0] o_addr,  // Address
  output logic      [7:0] o_wdata, // Write data
  output logic            o_wr,    // Write strobe
  output logic            o_rd     // Read strobe
);
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Released bus shows inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule

// *** dv/lcsr_regs_tb_top.sv ***
// Testbench for the regulator register bank.
// Assumes short step and retry counts set below.
`timescale 1ns/1ps
module lcsr_regs_tb_top;
  import lcsr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr, wdata, rdata, vcode;
  logic wr, rd, en, rstn, irqn, flt;
  logic [3:0] m1 = 4'h0, m2 = 4'h0;
  logic slp = 1'b0, dslp = 1'b0, start = 1'b0, prev = 1'b0;
  logic [1:0] isel;
  int failures = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  lcsr_host host_u (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  lcsr_regs #(.STEP_CYCLES(4), .RETRY_STEPS(3)) dut_u (
    .i_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_first_linear_regulator_mon(m1), .i_second_linear_regulator_mon(m2), .i_sleep_mode(slp),
    .i_deep_sleep_mode(dslp), .i_start_trigger(start),
    .i_prev_rail_down(prev), .o_first_linear_regulator_enable(en),
    .o_first_linear_regulator_ilim_sel(isel), .o_second_linear_regulator_vcode(vcode),
    .o_reset_output_n(rstn), .o_interrupt_output_n(irqn),
    .o_fault_state(flt));
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic endt(input string s);
    $display("test %s done, failures %0d", s, failures);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    cyc(3000);
    failures++;
    conclude;
  end
  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial
  begin
    cyc(2);
    rst = 1'b0;
    rchk(8'h62, 8'h98);
    rchk(8'h63, 8'h82);
    rchk(8'h64, 8'h00);
    rchk(8'h65, 8'h00);
    rchk(8'h66, 8'h50);
    rchk(8'h6A, 8'h00);
    chk({6'h0, isel}, 8'h03);
    endt("reset");
    for (int i = 0; i < 4; i++)
    begin
      host_u.wr(8'h62, {3'h4, i[1:0], 3'h0});
      cyc(1);
      chk({6'h0, isel}, i[7:0]);
    end
    host_u.wr(8'h66, 8'hA5);
    cyc(1);
    chk(vcode, 8'hA5);
    rchk(8'h66, 8'hA5);
    endt("fields");
    start = 1'b1;
    cyc(16);
    chk(en, 1);
    for (int m = 0; m < 2; m++)
    begin
      host_u.wr(8'h62, m ? 8'hB8 : 8'hD8);
      slp = !m;
      dslp = m;
      cyc(5);
      chk(en, 1);
      cyc(20);
      chk(en, 0);
      slp = 0;
      dslp = 0;
      cyc(14);
      chk(en, 1);
    end
    host_u.wr(8'h63, 8'hE2);
    start = 1'b0;
    cyc(8);
    chk(en, 0);
    start = 1'b1;
    cyc(12);
    chk(en, 0);
    cyc(18);
    chk(en, 1);
    prev = 1'b1;
    cyc(10);
    chk(en, 1);
    host_u.wr(8'h63, 8'h62);
    cyc(8);
    chk(en, 0);
    prev = 1'b0;
    host_u.wr(8'h62, 8'h18);
    cyc(30);
    chk(en, 0);
    host_u.wr(8'h62, 8'h98);
    cyc(30);
    chk(en, 1);
    endt("sequencing");
    m1 = 4'h2;
    cyc(10);
    chk(en, 1);
    chk(irqn, 0);
    host_u.wr(8'h62, 8'h9A);
    cyc(6);
    chk(en, 0);
    m1 = 4'h0;
    cyc(24);
    chk(en, 1);
    rchk(8'h60, 8'h20);
    rchk(8'h60, 8'h00);
    cyc(3);
    chk(irqn, 1);
    endt("limit");
    m2 = 4'h4;
    cyc(8);
    chk(irqn, 0);
    chk(flt, 1);
    rchk(8'h65, 8'h40);
    rchk(8'h65, 8'h40);
    m2 = 4'h0;
    cyc(8);
    chk(irqn, 0);
    rchk(8'h65, 8'h40);
    rchk(8'h65, 8'h00);
    cyc(3);
    chk({irqn, flt}, 8'h02);
    host_u.wr(8'h65, 8'h06);
    m2 = 4'h6;
    cyc(8);
    chk({irqn, flt}, 8'h02);
    m2 = 4'h0;
    cyc(8);
    rchk(8'h65, 8'h66);
    rchk(8'h65, 8'h06);
    m2 = 4'h1;
    cyc(8);
    chk({irqn, flt}, 8'h01);
    m2 = 4'h0;
    cyc(8);
    chk({irqn, flt}, 8'h02);
    host_u.wr(8'h65, 8'h0E);
    m2 = 4'h9;
    cyc(8);
    chk({irqn, flt}, 8'h02);
    rchk(8'h65, 8'h8E);
    m2 = 4'h0;
    cyc(8);
    rchk(8'h65, 8'h0E);
    endt("status");
    host_u.wr(8'h62, 8'h9C);
    cyc(4);
    chk(rstn, 0);
    m1 = 4'h8;
    cyc(8);
    chk(rstn, 1);
    endt("reset output");
    conclude;
  end
endmodule
